/* File: pfs_pkg.sv */
// Package with constants and types for the PID feedback supervisor and dwell block.
package pfs_pkg;

  // Loss mode encodings.
  localparam logic [1:0] PFS_LOSS_OFF  = 2'h0;
  localparam logic [1:0] PFS_LOSS_WARN = 2'h1;
  localparam logic [1:0] PFS_LOSS_TRIP = 2'h2;

  // Programmable input function codes.
  localparam logic [5:0] PFS_FN_PID_OFF   = 6'h13;
  localparam logic [5:0] PFS_FN_INT_RESET = 6'h1e;
  localparam logic [5:0] PFS_FN_INT_HOLD  = 6'h1f;
  // Programmable output function code for the feedback loss alarm.
  localparam logic [5:0] PFS_FN_FB_ALARM  = 6'h0a;

  // Number of programmable inputs and outputs.
  localparam int PFS_NUM_IN  = 6;
  localparam int PFS_NUM_OUT = 3;

  // Setting limits and reset values.
  localparam logic [6:0]  PFS_LVL_MAX       = 7'h64;   // 100 percent.
  localparam logic [6:0]  PFS_LVL_RESET     = 7'h00;
  localparam logic [7:0]  PFS_LTIME_RESET   = 8'h0a;   // 1.0 s in tenths.
  localparam logic [12:0] PFS_DFREQ_MAX     = 13'hfa0; // 400.0 Hz in tenths.
  localparam logic [6:0]  PFS_DTIME_MAX     = 7'h64;   // 10.0 s in tenths.

  // Timing: one tick per tenth of a second at 125 MHz.
  localparam int          PFS_CLK_HZ        = 125000000;
  localparam int          PFS_TICK_MS       = 100;
  localparam int          PFS_TICK_CYC      = PFS_CLK_HZ / 1000 * PFS_TICK_MS;

  // Dwell sequencer states.
  typedef enum logic [2:0] {
    PFS_ST_IDLE       = 3'b000,
    PFS_ST_START_DWELL = 3'b001,
    PFS_ST_RUN        = 3'b010,
    PFS_ST_STOP_DWELL = 3'b011,
    PFS_ST_TRIPPED    = 3'b100
  } pfs_state_t;

endpackage : pfs_pkg

/* File: pfs_tick_div.sv */
// Divider that makes the one-cycle tenth-of-a-second tick.
`timescale 1ns/100ps
module pfs_tick_div
  import pfs_pkg::*;
#(
  parameter int TICK_CYC = PFS_TICK_CYC
) (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Tick out.
  output logic      tick
);

  // Divider state held in one packed struct.
  typedef struct packed {
    logic [23:0] cnt;
    logic        tick;
  } pfs_div_t;

  pfs_div_t s_q;
  pfs_div_t s_d;

  // Count down and pulse once per period.
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 24'h0) begin
      s_d.cnt  = 24'(TICK_CYC - 1);
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt - 24'h1;
    end
  end

  // Register the divider.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : pfs_tick_div

/* File: pfs_persist.sv */
// Persistence timer that qualifies a condition for a number of ticks.
`timescale 1ns/100ps
module pfs_persist (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Condition and timing.
  input  wire logic       cond,
  input  wire logic       tick,
  input  wire logic [7:0] limit,
  // Qualified result.
  output logic            hit
);

  // Timer state held in one packed struct.
  typedef struct packed {
    logic [7:0] cnt;
    logic       hit;
  } pfs_per_t;

  pfs_per_t s_q;
  pfs_per_t s_d;

  // Restart when the condition drops; declare once the count reaches the limit.
  always_comb begin
    s_d = s_q;
    if (!cond) begin
      s_d.cnt = 8'h00;
      s_d.hit = 1'b0;
    end else if (s_q.cnt >= limit) begin
      s_d.hit = 1'b1;
    end else if (tick) begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  // Register the timer.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hit = s_q.hit;

endmodule : pfs_persist

/* File: pfs_supervisor.sv */
// Top of the PID feedback supervisor with mode inputs and dwell sequencer.
//
// What this block does
// - Mode 0 disables all feedback loss detection.
// - Mode 1 keeps running and raises warning.
// - Mode 2 trips and shuts drive output off.
// - Loss needs feedback below level for time.
// - Outputs coded 10 show alarm in warning.
// - Fault contact turns on in protective mode.
// - Loss level 0 to 100 percent, default 0.
// - Loss time 0.0 to 25.5 s, default 1.0.
// - Input coded 19 bypasses PID control.
// - Input coded 30 clears and stops integration.
// - Input coded 31 freezes the integral value.
// - Derivative time zero removes derivative term.
// - Hold dwell frequency for dwell time at start/stop.
// - Dwell settings ignored while the motor runs.
//
// All times count tenth-second ticks from one shared divider, so each may end up
// to one tick early; settings above their range are clamped rather than refused, except mode 3, which is taken as off.
`timescale 1ns/100ps
module pfs_supervisor
  import pfs_pkg::*;
#(
  parameter int TICK_CYC = PFS_TICK_CYC
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Feedback loss configuration.
  input  wire logic [1:0]  fb_loss_mode_sel,
  input  wire logic [6:0]  fb_loss_level,
  input  wire logic [7:0]  fb_loss_time,
  input  wire logic        cfg_load,
  // Feedback sample in percent of the maximum-frequency feedback value.
  input  wire logic [6:0]  fb_value,
  // PID configuration.
  input  wire logic [2:0]  pid_mode_sel,
  input  wire logic [11:0] pid_deriv_time,
  // Programmable inputs and their function codes.
  input  wire logic [5:0]  prog_in,
  input  wire logic [35:0] prog_input_func,
  // Programmable output function codes.
  input  wire logic [17:0] prog_output_func,
  // Run control and frequency path.
  input  wire logic        run_cmd,
  input  wire logic        fault_reset,
  input  wire logic [12:0] freq_ref,
  input  wire logic [12:0] dwell_start_freq,
  input  wire logic [6:0]  dwell_start_time,
  input  wire logic [12:0] dwell_stop_freq,
  input  wire logic [6:0]  dwell_stop_time,
  input  wire logic        dwell_load,
  // Frequency and PID control outputs.
  output logic [12:0]      freq_out,
  output logic             freq_hold,
  output logic             drive_enable,
  output logic             motor_running,
  output logic             pid_active,
  output logic             pid_int_clear,
  output logic             pid_int_freeze,
  output logic             pid_deriv_enable,
  // Status outputs.
  output logic             fb_loss_warn,
  output logic             fault_contact,
  output logic [2:0]       prog_out,
  output logic             dwell_load_rejected
);

  // Block state, apart from the divider and the persistence timer, in one packed struct. Settings, the sequencer state and every
  // registered output live here, so a single always_ff covers the rest of the block.
  typedef struct packed {
    pfs_state_t  st;
    logic [1:0]  mode;
    logic [6:0]  lvl;
    logic [7:0]  ltime;
    logic [12:0] d_start_f;
    logic [6:0]  d_start_t;
    logic [12:0] d_stop_f;
    logic [6:0]  d_stop_t;
    logic [6:0]  dcnt;
    logic [12:0] fout;
    logic        hold;
    logic        drv;
    logic        pid_on;
    logic        iclr;
    logic        ifrz;
    logic        den;
    logic        warn;
    logic        fault;
    logic [2:0]  pout;
    logic        rej;
  } pfs_top_t;

  // Present state and its next value.
  pfs_top_t s_q;
  pfs_top_t s_d;

  // Tenth-of-a-second tick.
  logic tick;
  // Persistence result for the low-feedback condition.
  logic loss_hit;
  // Raw low-feedback comparison, gated off in mode 0.
  logic below_lvl;
  // Decoded programmable input functions.
  logic [PFS_NUM_IN-1:0] in_pid_off;
  logic [PFS_NUM_IN-1:0] in_int_rst;
  logic [PFS_NUM_IN-1:0] in_int_hld;
  // Per-output alarm assignment.
  logic [PFS_NUM_OUT-1:0] out_is_alarm;

  // One divider serves both the loss timer and the dwell counter, so their
  // time bases can never drift apart.
  pfs_tick_div #(
    .TICK_CYC (TICK_CYC)
  ) u_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (tick)
  );

  // Detection is off entirely in mode 0 so no timer runs there.
  assign below_lvl = (s_q.mode != PFS_LOSS_OFF) && (fb_value < s_q.lvl);

  // The persistence timer counts ticks while the feedback stays low. Its first
  // tick lands anywhere in a tenth, so detection may come up to one tick early.
  pfs_persist u_persist (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cond    (below_lvl),
    .tick    (tick),
    .limit   (s_q.ltime),
    .hit     (loss_hit)
  );

  // Decode each programmable input and output against its function code.
  // The decode is purely combinational; the results are registered with the
  // rest of the state, so every PID qualifier lags its contact by one cycle.
  genvar gi;
  generate
    for (gi = 0; gi < PFS_NUM_IN; gi++) begin : g_in
      assign in_pid_off[gi] = prog_in[gi] && (prog_input_func[gi*6 +: 6] == PFS_FN_PID_OFF);
      assign in_int_rst[gi] = prog_in[gi] && (prog_input_func[gi*6 +: 6] == PFS_FN_INT_RESET);
      assign in_int_hld[gi] = prog_in[gi] && (prog_input_func[gi*6 +: 6] == PFS_FN_INT_HOLD);
    end
    // Outputs coded for the alarm follow the warning; all others stay low.
    for (gi = 0; gi < PFS_NUM_OUT; gi++) begin : g_out
      assign out_is_alarm[gi] = (prog_output_func[gi*6 +: 6] == PFS_FN_FB_ALARM);
    end
  endgenerate

  // Next-state logic for settings, status and the dwell sequencer.
  always_comb begin
    s_d     = s_q;
    // The refusal flag is a one-cycle pulse, so it starts low every cycle.
    s_d.rej = 1'b0;

    // Loss settings load with clamping to their allowed ranges.
    // Mode 3 is not defined and is taken as off, so a bad setting never trips.
    if (cfg_load) begin
      s_d.mode  = (fb_loss_mode_sel > PFS_LOSS_TRIP) ? PFS_LOSS_OFF : fb_loss_mode_sel;
      s_d.lvl   = (fb_loss_level > PFS_LVL_MAX) ? PFS_LVL_MAX : fb_loss_level;
      // Loss time needs no clamp: its eight bits already cover 0.0 to 25.5 s.
      s_d.ltime = fb_loss_time;
    end

    // Dwell settings only change while stopped; a write during running is refused.
    // Holding them while running keeps a dwell in progress from changing under way.
    if (dwell_load) begin
      if (s_q.st == PFS_ST_IDLE) begin
        s_d.d_start_f = (dwell_start_freq > PFS_DFREQ_MAX) ? PFS_DFREQ_MAX : dwell_start_freq;
        s_d.d_start_t = (dwell_start_time > PFS_DTIME_MAX) ? PFS_DTIME_MAX : dwell_start_time;
        s_d.d_stop_f  = (dwell_stop_freq > PFS_DFREQ_MAX) ? PFS_DFREQ_MAX : dwell_stop_freq;
        s_d.d_stop_t  = (dwell_stop_time > PFS_DTIME_MAX) ? PFS_DTIME_MAX : dwell_stop_time;
      end else begin
        // Refused: the pulse tells the operator that the load was dropped.
        s_d.rej = 1'b1;
      end
    end

    // Warning level follows the qualified loss in mode 1 only.
    // Warning and alarm outputs fall again as soon as the feedback recovers.
    s_d.warn = loss_hit && (s_q.mode == PFS_LOSS_WARN);
    s_d.pout = out_is_alarm & {PFS_NUM_OUT{s_d.warn}};

    // PID qualifiers: bypass, integral clear wins over hold.
    // Clear beats hold, so an integral that is being reset is never also frozen.
    s_d.pid_on = (pid_mode_sel != 3'h0) && !(|in_pid_off);
    s_d.iclr   = |in_int_rst;
    s_d.ifrz   = (|in_int_hld) && !(|in_int_rst);
    s_d.den    = (pid_deriv_time != 12'h000);

    // Dwell counter advances on ticks.
    // It stops at zero; the state machine below reloads it on entry to a dwell.
    if (tick && s_q.dcnt != 7'h00) begin
      s_d.dcnt = s_q.dcnt - 7'h01;
    end

    case (s_q.st)
      PFS_ST_IDLE: begin
        // Stopped: output off; a run command starts the start dwell.
        s_d.drv  = 1'b0;
        s_d.hold = 1'b0;
        s_d.fout = 13'h0000;
        if (run_cmd) begin
          // Drive comes on with the dwell, so a hold is never seen with the drive off.
          s_d.st   = PFS_ST_START_DWELL;
          s_d.dcnt = s_q.d_start_t;
          s_d.drv  = 1'b1;
        end
      end
      PFS_ST_START_DWELL: begin
        // Hold the start frequency until the dwell time is spent.
        s_d.fout = s_q.d_start_f;
        s_d.hold = 1'b1;
        if (s_q.dcnt == 7'h00) begin
          // A dwell time of zero leaves this state after one cycle.
          s_d.st   = PFS_ST_RUN;
          s_d.hold = 1'b0;
        end
      end
      PFS_ST_RUN: begin
        // Follow the reference with one cycle of latency.
        s_d.fout = freq_ref;
        s_d.hold = 1'b0;
        if (!run_cmd) begin
          // Removing the run command begins the stop dwell.
          s_d.st   = PFS_ST_STOP_DWELL;
          s_d.dcnt = s_q.d_stop_t;
        end
      end
      PFS_ST_STOP_DWELL: begin
        // Hold the stop frequency, then release the output.
        s_d.fout = s_q.d_stop_f;
        s_d.hold = 1'b1;
        if (s_q.dcnt == 7'h00) begin
          // Stop dwell done: release the drive and return to stopped.
          s_d.st   = PFS_ST_IDLE;
          s_d.drv  = 1'b0;
          s_d.hold = 1'b0;
          s_d.fout = 13'h0000;
        end
      end
      PFS_ST_TRIPPED: begin
        // The output stays off until a fault reset with the run command removed.
        s_d.drv  = 1'b0;
        s_d.hold = 1'b0;
        s_d.fout = 13'h0000;
        // Leaving needs the loss gone too, or the fault would latch again at once.
        if (fault_reset && !run_cmd && !loss_hit) begin
          s_d.st    = PFS_ST_IDLE;
          s_d.fault = 1'b0;
        end
      end
      default: begin
        // An unused state code falls back to stopped.
        s_d.st = PFS_ST_IDLE;
      end
    endcase

    // Protective mode overrides every state: shut off and latch the fault contact.
    // It stands last so that it wins over every state transition above.
    if (loss_hit && s_q.mode == PFS_LOSS_TRIP && s_q.st != PFS_ST_TRIPPED) begin
      s_d.st    = PFS_ST_TRIPPED;
      s_d.drv   = 1'b0;
      s_d.hold  = 1'b0;
      s_d.fout  = 13'h0000;
      s_d.fault = 1'b1;
    end
  end

  // Register the whole state; loss time resets to 1.0 s, all else to zero.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Every field to zero first, then the few with named reset values; only loss time is not zero.
      s_q       <= '0;
      s_q.st    <= PFS_ST_IDLE;
      s_q.lvl   <= PFS_LVL_RESET;
      s_q.ltime <= PFS_LTIME_RESET;
    end else begin
      // Take the next state as a whole.
      s_q <= s_d;
    end
  end

  // Outputs straight from the registered state.
  // Data outputs come from flip-flops, so they change only at clock edges; motor
  // running is decoded from the state register and adds no latency of its own.
  assign freq_out            = s_q.fout;
  assign freq_hold           = s_q.hold;
  assign drive_enable        = s_q.drv;
  assign motor_running       = (s_q.st != PFS_ST_IDLE) && (s_q.st != PFS_ST_TRIPPED);
  assign pid_active          = s_q.pid_on;
  assign pid_int_clear       = s_q.iclr;
  assign pid_int_freeze      = s_q.ifrz;
  assign pid_deriv_enable    = s_q.den;
  assign fb_loss_warn        = s_q.warn;
  assign fault_contact       = s_q.fault;
  assign prog_out            = s_q.pout;
  assign dwell_load_rejected = s_q.rej;

endmodule : pfs_supervisor

/* File: pfs_properties.sv */
// Checker that watches the ports of the feedback supervisor.
`timescale 1ns/100ps
module pfs_properties
  import pfs_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [11:0] pid_deriv_time,
  input wire logic [5:0]  prog_in,
  input wire logic [35:0] prog_input_func,
  input wire logic        run_cmd,
  input wire logic        fault_reset,
  input wire logic        dwell_load,
  // Outputs.
  input wire logic [12:0] freq_out,
  input wire logic        freq_hold,
  input wire logic        drive_enable,
  input wire logic        motor_running,
  input wire logic        pid_active,
  input wire logic        pid_int_clear,
  input wire logic        pid_int_freeze,
  input wire logic        pid_deriv_enable,
  input wire logic        fb_loss_warn,
  input wire logic        fault_contact,
  input wire logic [2:0]  prog_out,
  input wire logic        dwell_load_rejected
);
  logic [2:0] req;  // Bypass, clear and hold asked by any closed contact.

  // Decodes the contact functions the same way for every input.
  always_comb begin
    req = 3'h0;
    for (int i = 0; i < PFS_NUM_IN; i++) begin
      if (prog_in[i]) begin
        req |= {prog_input_func[6*i+:6] == PFS_FN_PID_OFF, prog_input_func[6*i+:6] == PFS_FN_INT_RESET,
                prog_input_func[6*i+:6] == PFS_FN_INT_HOLD};
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // The past of reset guards the first edge, where registers still hold reset values.
  a_bypass_pid: assert property (pid_active |-> !$past(req[2]))
    else $error("pid active while bypassed");
  a_int_clear: assert property ($past(rst_n) |-> pid_int_clear == $past(req[1]))
    else $error("integral clear wrong");
  a_int_hold: assert property ($past(rst_n) |-> pid_int_freeze == ($past(req[0]) && !$past(req[1])))
    else $error("integral hold wrong");
  a_deriv_off: assert property ($past(rst_n) |-> pid_deriv_enable == ($past(pid_deriv_time) != 12'h000))
    else $error("derivative enable wrong");
  a_alarm_warn: assert property (prog_out != 3'h0 |-> fb_loss_warn)
    else $error("alarm output without warning");
  a_fault_held: assert property (fault_contact && !fault_reset |=> fault_contact)
    else $error("fault contact dropped");
  a_trip_off: assert property (fault_contact && $past(fault_contact) |-> !drive_enable && freq_out == 13'h0000)
    else $error("drive on after trip");
  a_dwell_reject: assert property (dwell_load && motor_running |=> dwell_load_rejected)
    else $error("dwell load while running not refused");
  a_hold_drive: assert property (freq_hold |-> drive_enable)
    else $error("dwell hold without drive");
  a_start_run: assert property ($rose(drive_enable) |-> $past(run_cmd))
    else $error("drive started without run");
endmodule : pfs_properties

bind pfs_supervisor pfs_properties i_props (.*);

/* File: pfs_sense_model.sv */
// Behavioural feedback sensor and contact bank in front of the supervisor.
`timescale 1ns/100ps
module pfs_sense_model (
  // Clock and scenario control.
  input  wire logic       sys_clk,
  input  wire logic       lost,
  input  wire logic [6:0] level,
  input  wire logic [5:0] contacts,
  // Sensor and contact levels.
  output logic [6:0]      fb_value,
  output logic [5:0]      prog_in
);
  int         seed = 32'h8870;  // Noise source for the sensor reading.
  int         v;                // Fresh noise each cycle.
  logic [6:0] lvl;              // Level held at full scale, as the block holds it.

  // A broken line reads noise under the level, a good one noise at or above it.
  // One process owns both outputs, from their start values onwards.
  initial begin
    fb_value = 7'h00;
    prog_in  = 6'h00;
    forever begin
      @(posedge sys_clk);
      #3;
      v   = $unsigned($random(seed)) % 128;
      lvl = (level > 7'h64) ? 7'h64 : level;
      if (lost) begin
        fb_value <= (lvl == 7'h00) ? 7'h00 : 7'(v % lvl);
      end else begin
        fb_value <= 7'(lvl + v % (101 - lvl));
      end
      prog_in <= contacts;
    end
  end
endmodule : pfs_sense_model

/* File: pfs_supervisor_test.sv */
// Self-checking testbench for the feedback supervisor.
`timescale 1ns/100ps
module pfs_supervisor_test
  import pfs_pkg::*;
;
  typedef struct packed {logic [1:0] kind; logic [12:0] val;} pfs_note_t;
  logic        sys_clk, rst_n, cfg_load, run_cmd, fault_reset, dwell_load, lost;
  logic [1:0]  fb_loss_mode_sel;
  logic [6:0]  fb_loss_level, fb_value, dwell_start_time, dwell_stop_time;
  logic [7:0]  fb_loss_time;
  logic [2:0]  pid_mode_sel, prog_out;
  logic [11:0] pid_deriv_time;
  logic [5:0]  prog_in, contacts;
  logic [35:0] prog_input_func;
  logic [17:0] prog_output_func;
  logic [12:0] freq_ref, dwell_start_freq, dwell_stop_freq, freq_out;
  logic        freq_hold, drive_enable, motor_running, pid_active, pid_int_clear;
  logic        pid_int_freeze, pid_deriv_enable, fb_loss_warn, fault_contact, dwell_load_rejected;
  logic [3:0]  pid_exp [4] = '{4'h1, 4'hc, 4'hb, 4'hc};
  pfs_note_t   notes[$];
  int          seed = 32'h8870;
  int          n_mismatch = 0;
  int          checks = 0;
  int          idx;

  pfs_sense_model i_sense (.sys_clk, .lost, .level(fb_loss_level), .contacts, .fb_value, .prog_in);
  // A short tick keeps tenths of a second at ten cycles.
  pfs_supervisor #(.TICK_CYC(10)) i_dut (.*);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : step

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Takes the oldest note off the queue whenever an output event rises.
  initial begin
    logic [3:0]  prev;
    logic [3:0]  now;
    logic [12:0] got [4];
    pfs_note_t   n;
    prev = 4'h0;
    forever begin
      @(posedge sys_clk);
      #1;
      now = {freq_hold, dwell_load_rejected, fault_contact, fb_loss_warn};
      got = '{{10'h0, prog_out}, {12'h0, fb_loss_warn}, {12'h0, motor_running}, freq_out};
      for (int k = 0; k < 4; k++) begin
        if (now[k] && !prev[k]) begin
          check(16'(notes.size() != 0), 16'h1);
          n = notes.pop_front();
          check({14'h0, n.kind}, k[15:0]);
          check({3'h0, got[k]}, {3'h0, n.val});
        end
      end
      prev = now;
    end
  end

  // Cuts a hang short well after the whole sequence should be done.
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    {rst_n, cfg_load, run_cmd, fault_reset, dwell_load, lost} = 6'h00;
    {fb_loss_mode_sel, fb_loss_level, fb_loss_time, pid_mode_sel, pid_deriv_time} = 32'h0;
    {contacts, prog_input_func, freq_ref} = 55'h0;
    {dwell_start_freq, dwell_start_time, dwell_stop_freq, dwell_stop_time} = 40'h0;
    prog_output_func = {6'h0a, 6'h00, 6'h0a};  // Outputs 0 and 2 carry the alarm.
    repeat (12) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    step(1);
    check({fb_loss_warn, fault_contact, drive_enable, freq_out}, 16'h0);
    // Short dwells at zero frequency give every start, and the stops in modes 0 and 1, a visible hold.
    {dwell_start_time, dwell_stop_time, dwell_load} = {7'h01, 7'h01, 1'b1};
    step(1);
    dwell_load = 1'b0;
    // Each mode: a loss broken by one good sample, then a loss that lasts.
    for (int m = 0; m < 3; m++) begin
      {fb_loss_mode_sel, fb_loss_level, fb_loss_time, cfg_load} = {m[1:0], 7'h32, 8'h03, 1'b1};
      step(1);
      notes.push_back({2'h3, 13'h0});
      {cfg_load, run_cmd} = 2'b01;
      step(5);
      lost = 1'b1;
      step(20);
      lost = 1'b0;
      step(1);
      lost = 1'b1;
      step(19);
      check({15'h0, fb_loss_warn | fault_contact}, 16'h0);
      if (m > 0) notes.push_back({1'b0, m == 2, 10'h0, m == 1, 1'b0, m == 1});
      step(16);
      check({fb_loss_warn, fault_contact, drive_enable}, (m == 0) ? 3'h1 : (m == 1) ? 3'h5 : 3'h2);
      if (m < 2) notes.push_back({2'h3, 13'h0});
      {lost, run_cmd, fault_reset} = 3'b001;
      step(3);
      fault_reset = 1'b0;
      step(3);
      check({15'h0, fault_contact}, 16'h0);
    end
    // A level above range is held at full scale, and a zero time declares loss at once.
    {fb_loss_mode_sel, fb_loss_level, fb_loss_time, cfg_load} = {2'h1, 7'h7f, 8'h00, 1'b1};
    step(1);
    cfg_load = 1'b0;
    step(6);
    check({15'h0, fb_loss_warn}, 16'h0);
    notes.push_back({2'h0, 13'h0005});
    lost = 1'b1;
    step(4);
    check({15'h0, fb_loss_warn}, 16'h1);
    lost = 1'b0;
    step(3);
    // Every contact closed, one coded at a random input, plus a hold code at the next input in the last pass.
    pid_mode_sel = 3'h1;
    for (int k = 0; k < 4; k++) begin
      idx = $unsigned($random(seed)) % 6;
      prog_input_func = 36'h0;
      prog_input_func[6*idx+:6] = (k == 0) ? PFS_FN_PID_OFF : (k == 2) ? PFS_FN_INT_HOLD : PFS_FN_INT_RESET;
      if (k == 3) prog_input_func[6*((idx+1)%6)+:6] = PFS_FN_INT_HOLD;
      contacts = 6'h3f;
      pid_deriv_time = k[0] ? 12'h000 : 12'(($unsigned($random(seed)) % 4095) + 1);
      step(3);
      check({pid_active, pid_int_clear, pid_int_freeze, pid_deriv_enable}, pid_exp[k]);
    end
    // Dwell at start, a refused load while running, dwell at stop.
    contacts = 6'h00;
    {dwell_start_freq, dwell_start_time, dwell_stop_freq, dwell_stop_time, dwell_load} = {13'h07b, 7'h02, 13'h02d, 7'h01, 1'b1};
    freq_ref = PFS_DFREQ_MAX;
    step(1);
    dwell_load = 1'b0;
    notes.push_back({2'h3, 13'h007b});
    run_cmd = 1'b1;
    step(40);
    check({3'h0, freq_out}, {3'h0, freq_ref});
    notes.push_back({2'h2, 13'h0001});
    {dwell_stop_freq, dwell_load} = {13'h0111, 1'b1};
    step(1);
    dwell_load = 1'b0;
    notes.push_back({2'h3, 13'h002d});
    step(1);
    run_cmd = 1'b0;
    step(30);
    check({freq_hold, drive_enable, freq_out}, 15'h0);
    check(16'(notes.size()), 16'h0);
    stop_test();
  end
endmodule : pfs_supervisor_test
